//--- core/cgs_pkg.sv
// Shared constants, types and register map of the clock generator
package cgs_pkg;
  // Clock rates in kHz
  localparam int CLK_KHZ        = 25000;
  localparam int HS_OSC_KHZ     = 8000;
  localparam int LS_OSC_KHZ     = 240;
  // Supply/regulator settle wait in the low-threshold power-on mode
  localparam int REG_STAB_US    = 100;
  localparam int REG_STAB_CYC   = (REG_STAB_US * CLK_KHZ + 999) / 1000;
  localparam int RESET_PROC_CYC = 8;
  // Register byte offsets
  localparam logic [7:0] ADDR_OSC_MODE  = 8'h00;
  localparam logic [7:0] ADDR_INT_OSC   = 8'h04;
  localparam logic [7:0] ADDR_MAIN_OSC  = 8'h08;
  localparam logic [7:0] ADDR_MAIN_SEL  = 8'h0C;
  localparam logic [7:0] ADDR_STAB_STAT = 8'h10;
  localparam logic [7:0] ADDR_STAB_SEL  = 8'h14;
  localparam logic [7:0] ADDR_CPU_CLK   = 8'h18;
  localparam logic [7:0] ADDR_PORT12    = 8'h1C;
  localparam logic [7:0] ADDR_STANDBY   = 8'h20;
  // Reset values
  localparam logic [7:0] OSC_MODE_RST   = 8'h00;
  localparam logic [7:0] INT_OSC_RST    = 8'h00;
  localparam logic [7:0] MAIN_OSC_RST   = 8'h80;
  localparam logic [7:0] MAIN_SEL_RST   = 8'h00;
  localparam logic [7:0] STAB_SEL_RST   = 8'h05;
  localparam logic [7:0] CPU_CLK_RST    = 8'h01;
  localparam logic [7:0] PORT12_RST     = 8'hFF;
  // Field positions
  localparam int SUBPIN_BIT   = 4;
  localparam int EXT_SUB_BIT  = 5;
  localparam int MAINPIN_BIT  = 6;
  localparam int EXT_MAIN_BIT = 7;
  localparam int HS_STOP_BIT  = 0;
  localparam int LS_STOP_BIT  = 1;
  localparam int MAIN_OSC_STOP_BIT    = 7;
  localparam int MAIN_SEL_BIT = 0;
  localparam int MAIN_STS_BIT = 1;
  localparam int SUB_SEL_BIT  = 4;
  localparam int SUB_STS_BIT  = 5;
  localparam int PIN1_DIR_BIT = 3;
  localparam int PIN2_DIR_BIT = 4;
  localparam int STOP_CMD_BIT = 0;
  localparam int HALTED_BIT   = 1;
  // Stabilization select codes and crystal-cycle exponents
  localparam logic [2:0] STAB_CODE_MIN = 3'h1;
  localparam logic [2:0] STAB_CODE_MAX = 3'h5;
  localparam int STAB_EXP [5] = '{11, 13, 14, 15, 16};
  localparam logic [2:0] DIV_MAX = 3'h4;
  // CPU clock sources
  localparam logic [1:0] SRC_HS   = 2'h0;
  localparam logic [1:0] SRC_MAIN = 2'h1;
  localparam logic [1:0] SRC_SUB  = 2'h2;

  // Start-up option straps
  typedef struct packed {
    logic ls_stoppable;
    logic wdt_enable;
    logic poweron_clear_mode;
  } cgs_option_s;

  // Oscillator enable pulses
  typedef struct packed {
    logic hs;
    logic main;
    logic sub;
  } cgs_tick_s;

  // Power and standby sequence
  typedef enum logic [5:0] {
    ST_POR       = 6'h01,
    ST_REG_WAIT  = 6'h02,
    ST_RST_PROC  = 6'h04,
    ST_RUN       = 6'h08,
    ST_STOP      = 6'h10,
    ST_STOP_WAIT = 6'h20
  } cgs_state_e;
endpackage : cgs_pkg

//--- core/cgs_cpu_clock_mux.sv
// CPU clock source selection and prescaler
`timescale 1ns/100ps
`default_nettype none
module cgs_cpu_clock_mux (
  input  wire logic              clk_in,       // System clock
  input  wire logic              reset_in,     // Sync reset, high
  input  wire cgs_pkg::cgs_tick_s ticks_in,    // Oscillator pulses
  input  wire logic              main_sel_in,  // Main clock on high-speed system clock
  input  wire logic              sub_sel_in,   // CPU on subsystem clock
  input  wire logic [2:0]        div_in,       // Prescaler exponent
  input  wire logic              run_in,       // CPU may run
  output logic                   cpu_tick_out, // CPU clock pulse
  output logic                   prs_tick_out, // Peripheral clock pulse
  output logic [1:0]             src_out       // Source in use
);
  import cgs_pkg::*;

  logic [1:0] src_r;
  logic [3:0] cnt_r;
  logic [3:0] mask;
  logic       fxp_tick;
  logic       bound;
  logic [1:0] req_src;

  // Divided main system clock; sub clock bypasses the prescaler
  always_comb begin
    mask     = 4'((5'h01 << div_in) - 5'h01);
    fxp_tick = (src_r == SRC_MAIN) ? ticks_in.main : ticks_in.hs;
    if (src_r == SRC_SUB) begin
      bound = ticks_in.sub;
    end else begin
      bound = fxp_tick && ((cnt_r & mask) == mask);
    end
    if (sub_sel_in) begin
      req_src = SRC_SUB;
    end else if (main_sel_in) begin
      req_src = SRC_MAIN;
    end else begin
      req_src = SRC_HS;
    end
  end

  // Source only changes at a full period boundary
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      src_r <= SRC_HS;
      cnt_r <= 4'h0;
    end else begin
      if (bound) begin
        src_r <= req_src;
        cnt_r <= 4'h0;
      end else if (fxp_tick && src_r != SRC_SUB) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cpu_tick_out <= 1'b0;
      prs_tick_out <= 1'b0;
      src_out      <= SRC_HS;
    end else begin
      cpu_tick_out <= bound && run_in;
      prs_tick_out <= main_sel_in ? ticks_in.main : ticks_in.hs;
      src_out      <= src_r;
    end
  end
endmodule : cgs_cpu_clock_mux
`default_nettype wire

//--- core/cgs_clock_generator.sv
// Clock generator start-up, oscillator control and stabilization status
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - High-speed oscillator starts itself at 8 MHz
// - Low-speed clock feeds only watchdog, timer one
// - Low-speed stop allowed only when strap permits
// - Low-speed oscillator starts; 240 kHz watchdog clock
// - CPU starts on internal high-speed clock
// - Prescaler divides main system clock for CPU
// - Port 12 bits 3,4: 1 input, 0 output
// - Mode 0: release above 1.59 V
// - Mode 1: release above 2.7 V
// - Mode 0 waits regulator settle before running
// - Mode 1 does reset processing directly
// - STOP release on crystal waits selected time
// - External clock input needs no wait
// - STOP halts internal high-speed and main clocks
// - Unused clocks may be stopped by software
// - Select codes 1 to 5, reset 05H
// - Status bits set in order, stay set
// - Reset, STOP, main stop clear status
module cgs_clock_generator #(
  parameter int STAB_SHIFT = 0 // Shortens crystal waits by 2^n
) (
  input  wire logic                 clk_in,               // 25 MHz clock
  input  wire logic                 reset_in,             // Sync reset, high
  input  wire logic [7:0]           avs_address_in,       // Byte address
  input  wire logic                 avs_read_in,          // Read request
  input  wire logic                 avs_write_in,         // Write request
  input  wire logic [31:0]          avs_writedata_in,     // Write data
  output logic [31:0]               avs_readdata_out,     // Read data
  output logic                      avs_waitrequest_out,  // Stall
  input  wire cgs_pkg::cgs_option_s option_straps_in,     // Start-up options
  input  wire logic                 supply_1v59_ok_in,    // Supply above 1.59 V
  input  wire logic                 supply_2v7_ok_in,     // Supply above 2.7 V
  input  wire logic                 stop_release_in,      // STOP wake event
  input  wire logic                 main_crystal_osc_in,  // Crystal main pulse
  input  wire logic                 ext_main_clock_pin_in,// External main pulse
  input  wire logic                 sub_crystal_osc_in,   // Crystal sub pulse
  input  wire logic                 ext_sub_clock_pin_in, // External sub pulse
  input  wire logic [1:0]           subclock_pin_data_in, // Port data to pins
  output logic                      cpu_clk_en_out,       // CPU clock pulse
  output logic                      periph_clk_en_out,    // Peripheral clock pulse
  output logic                      watchdog_clk_en_out,  // Watchdog clock pulse
  output logic                      timer_one_ls_en_out,  // Timer one low-speed pulse
  output logic                      cpu_reset_out,        // CPU held in reset
  output logic                      cpu_halted_out,       // CPU in STOP
  output logic                      hs_osc_on_out,        // Internal fast osc on
  output logic                      ls_osc_on_out,        // Internal slow osc on
  output logic                      main_osc_on_out,      // Main osc enabled
  output logic                      sub_osc_on_out,       // Sub osc enabled
  output logic [1:0]                subclock_pin_out,     // Pin output data
  output logic [1:0]                subclock_pin_oe_out   // Pin drive enable
);
  import cgs_pkg::*;

  cgs_state_e  state_r;
  cgs_option_s opt_r;
  logic [11:0] seq_cnt_r;
  logic [7:0]  osc_mode_r;
  logic [7:0]  int_osc_r;
  logic        main_osc_stop_r;
  logic        main_sel_r;
  logic [2:0]  stab_sel_r;
  logic [2:0]  div_r;
  logic        sub_sel_r;
  logic [1:0]  pin_dir_r;
  logic [4:0]  stab_stat_r;
  logic [16:0] stab_cnt_r;
  logic        wait_r;
  logic        acc;
  logic        wr_en;
  logic        sys_rst;
  logic        in_stop;
  logic        supply_ok;
  logic        hs_on;
  logic        ls_on;
  logic        main_on;
  logic        main_ext;
  logic        stab_clr;
  logic        stab_done;
  logic [7:0]  rd_mux;
  logic [7:0]  wd;
  logic [1:0]  cur_src;
  logic        cpu_tick;
  logic        prs_tick;
  logic [1:0]  osc_tick;
  logic [1:0]  osc_on;
  cgs_tick_s   ticks;

  // Supply threshold chosen by the power-on-clear strap
  always_comb begin
    if (opt_r.poweron_clear_mode) begin
      supply_ok = supply_2v7_ok_in;
    end else begin
      supply_ok = supply_1v59_ok_in;
    end
  end

  assign sys_rst  = reset_in || (state_r == ST_POR);
  assign in_stop  = (state_r == ST_STOP);
  assign acc      = (avs_read_in || avs_write_in) && !wait_r;
  assign wr_en    = acc && avs_write_in;
  assign wd       = avs_writedata_in[7:0];
  assign main_ext = osc_mode_r[EXT_MAIN_BIT];

  // Oscillator run conditions
  always_comb begin
    hs_on   = !sys_rst && !in_stop && !int_osc_r[HS_STOP_BIT];
    ls_on   = !sys_rst && !(opt_r.ls_stoppable && int_osc_r[LS_STOP_BIT]);
    main_on = !sys_rst && !in_stop && osc_mode_r[MAINPIN_BIT] && !main_osc_stop_r;
    osc_on  = {ls_on, hs_on};
  end

  // Internal oscillators as phase accumulators on the system clock
  for (genvar g = 0; g < 2; g++) begin : g_int_osc
    localparam logic [14:0] INC = 15'((g == 0) ? HS_OSC_KHZ : LS_OSC_KHZ);
    logic [14:0] acc_r;
    always_ff @(posedge clk_in) begin
      if (!osc_on[g]) begin
        acc_r       <= 15'h0000;
        osc_tick[g] <= 1'b0;
      end else if (acc_r + INC >= 15'(CLK_KHZ)) begin
        acc_r       <= acc_r + INC - 15'(CLK_KHZ);
        osc_tick[g] <= 1'b1;
      end else begin
        acc_r       <= acc_r + INC;
        osc_tick[g] <= 1'b0;
      end
    end
  end

  // Oscillator pulses into the CPU clock mux
  always_comb begin
    ticks.hs   = osc_tick[0];
    ticks.main = main_on && (main_ext ? ext_main_clock_pin_in : main_crystal_osc_in);
    ticks.sub  = osc_mode_r[SUBPIN_BIT] &&
                 (osc_mode_r[EXT_SUB_BIT] ? ext_sub_clock_pin_in : sub_crystal_osc_in);
  end

  cgs_cpu_clock_mux u_mux (
    .clk_in       (clk_in),
    .reset_in     (sys_rst),
    .ticks_in     (ticks),
    .main_sel_in  (main_sel_r),
    .sub_sel_in   (sub_sel_r),
    .div_in       (div_r),
    .run_in       (state_r == ST_RUN),
    .cpu_tick_out (cpu_tick),
    .prs_tick_out (prs_tick),
    .src_out      (cur_src)
  );

  // Straps are sampled while held in power-on reset, then frozen
  always_ff @(posedge clk_in) begin
    if (state_r == ST_POR) begin
      opt_r <= option_straps_in;
    end
  end

  // Power-on and standby sequence
  always_ff @(posedge clk_in) begin
    if (reset_in || !supply_ok) begin
      state_r   <= ST_POR;
      seq_cnt_r <= 12'h000;
    end else begin
      seq_cnt_r <= seq_cnt_r + 12'h001;
      unique case (state_r)
        ST_POR: begin
          seq_cnt_r <= 12'h000;
          state_r   <= opt_r.poweron_clear_mode ? ST_RST_PROC : ST_REG_WAIT;
        end
        ST_REG_WAIT: begin
          if (seq_cnt_r == 12'(REG_STAB_CYC - 1)) begin
            seq_cnt_r <= 12'h000;
            state_r   <= ST_RST_PROC;
          end
        end
        ST_RST_PROC: begin
          if (seq_cnt_r == 12'(RESET_PROC_CYC - 1)) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (wr_en && avs_address_in == ADDR_STANDBY && wd[STOP_CMD_BIT]) begin
            state_r <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (stop_release_in) begin
            state_r <= (cur_src == SRC_MAIN) ? ST_STOP_WAIT : ST_RUN;
          end
        end
        ST_STOP_WAIT: begin
          if (stab_done) begin
            state_r <= ST_RUN;
          end
        end
      endcase
    end
  end

  // Pin and oscillator mode bits; sub osc cannot stop while it clocks the CPU
  always_ff @(posedge clk_in) begin
    if (sys_rst) begin
      osc_mode_r <= OSC_MODE_RST;
      pin_dir_r  <= {PORT12_RST[PIN2_DIR_BIT], PORT12_RST[PIN1_DIR_BIT]};
    end else if (wr_en) begin
      if (avs_address_in == ADDR_OSC_MODE) begin
        osc_mode_r <= {wd[7:4], 4'h0};
        if (cur_src == SRC_SUB || sub_sel_r) begin
          osc_mode_r[SUBPIN_BIT] <= osc_mode_r[SUBPIN_BIT];
        end
      end
      if (avs_address_in == ADDR_PORT12) begin
        pin_dir_r <= {wd[PIN2_DIR_BIT], wd[PIN1_DIR_BIT]};
      end
    end
  end

  // Oscillator stop bits; the clock in use by the CPU is never stopped
  always_ff @(posedge clk_in) begin
    if (sys_rst) begin
      int_osc_r <= INT_OSC_RST;
      main_osc_stop_r   <= MAIN_OSC_RST[MAIN_OSC_STOP_BIT];
    end else if (wr_en) begin
      if (avs_address_in == ADDR_INT_OSC) begin
        int_osc_r[LS_STOP_BIT] <= wd[LS_STOP_BIT];
        if (cur_src != SRC_HS && main_sel_r) begin
          int_osc_r[HS_STOP_BIT] <= wd[HS_STOP_BIT];
        end
      end
      if (avs_address_in == ADDR_MAIN_OSC && !(wd[MAIN_OSC_STOP_BIT] && cur_src == SRC_MAIN)) begin
        main_osc_stop_r <= wd[MAIN_OSC_STOP_BIT];
      end
    end
  end

  // Clock selection and prescaler setting
  always_ff @(posedge clk_in) begin
    if (sys_rst) begin
      main_sel_r <= MAIN_SEL_RST[MAIN_SEL_BIT];
      sub_sel_r  <= CPU_CLK_RST[SUB_SEL_BIT];
      div_r      <= CPU_CLK_RST[2:0];
      stab_sel_r <= STAB_SEL_RST[2:0];
    end else if (wr_en) begin
      if (avs_address_in == ADDR_MAIN_SEL) begin
        main_sel_r <= wd[MAIN_SEL_BIT];
      end
      if (avs_address_in == ADDR_CPU_CLK) begin
        sub_sel_r <= wd[SUB_SEL_BIT];
        if (wd[2:0] <= DIV_MAX) begin
          div_r <= wd[2:0];
        end
      end
      if (avs_address_in == ADDR_STAB_SEL && wd[2:0] >= STAB_CODE_MIN && wd[2:0] <= STAB_CODE_MAX) begin
        stab_sel_r <= wd[2:0];
      end
    end
  end

  // Clear during reset, in STOP or while the main oscillator is stopped
  assign stab_clr = sys_rst || in_stop || main_osc_stop_r;

  // Crystal cycle counter, capped at the selected wait
  always_ff @(posedge clk_in) begin
    if (stab_clr || main_ext) begin
      stab_cnt_r <= 17'h00000;
    end else if (ticks.main && !stab_done) begin
      stab_cnt_r <= stab_cnt_r + 17'h00001;
    end
  end

  // Status bits, bit 4 for the shortest wait, set in order and held
  for (genvar i = 0; i < 5; i++) begin : g_stab
    localparam logic [16:0] THR = 17'(17'h00001 << (STAB_EXP[i] - STAB_SHIFT));
    always_ff @(posedge clk_in) begin
      if (stab_clr) begin
        stab_stat_r[4 - i] <= 1'b0;
      end else if (main_on && i < int'(stab_sel_r) && (main_ext || stab_cnt_r >= THR)) begin
        stab_stat_r[4 - i] <= 1'b1;
      end
    end
  end

  // Selected wait reached: the status bit of the selected code
  assign stab_done = main_ext ? main_on : stab_stat_r[3'd5 - stab_sel_r];

  // Register read multiplexer
  always_comb begin
    unique case (avs_address_in)
      ADDR_OSC_MODE:  rd_mux = osc_mode_r;
      ADDR_INT_OSC:   rd_mux = int_osc_r;
      ADDR_MAIN_OSC:  rd_mux = {main_osc_stop_r, 7'h00};
      ADDR_MAIN_SEL:  rd_mux = {6'h00, cur_src == SRC_MAIN, main_sel_r};
      ADDR_STAB_STAT: rd_mux = {3'h0, stab_stat_r};
      ADDR_STAB_SEL:  rd_mux = {5'h00, stab_sel_r};
      ADDR_CPU_CLK:   rd_mux = {2'h0, cur_src == SRC_SUB, sub_sel_r, 1'b0, div_r};
      ADDR_PORT12:    rd_mux = {3'h7, pin_dir_r, 3'h7};
      ADDR_STANDBY:   rd_mux = {6'h00, cpu_halted_out, 1'b0};
      default:        rd_mux = 8'h00;
    endcase
  end

  // Avalon slave: one wait cycle, then the access completes
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wait_r           <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      wait_r <= !((avs_read_in || avs_write_in) && wait_r);
      if (avs_read_in && wait_r) begin
        avs_readdata_out <= {24'h00_0000, rd_mux};
      end
    end
  end
  assign avs_waitrequest_out = wait_r;

  // Clock enables and status outputs
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cpu_clk_en_out      <= 1'b0;
      periph_clk_en_out   <= 1'b0;
      watchdog_clk_en_out <= 1'b0;
      timer_one_ls_en_out <= 1'b0;
      cpu_reset_out       <= 1'b1;
      cpu_halted_out      <= 1'b0;
      hs_osc_on_out       <= 1'b0;
      ls_osc_on_out       <= 1'b0;
      main_osc_on_out     <= 1'b0;
      sub_osc_on_out      <= 1'b0;
    end else begin
      cpu_clk_en_out      <= cpu_tick;
      periph_clk_en_out   <= prs_tick;
      watchdog_clk_en_out <= osc_tick[1] && opt_r.wdt_enable;
      timer_one_ls_en_out <= osc_tick[1];
      cpu_reset_out       <= state_r == ST_POR || state_r == ST_REG_WAIT || state_r == ST_RST_PROC;
      cpu_halted_out      <= in_stop || state_r == ST_STOP_WAIT;
      hs_osc_on_out       <= hs_on;
      ls_osc_on_out       <= ls_on;
      main_osc_on_out     <= main_on;
      sub_osc_on_out      <= osc_mode_r[SUBPIN_BIT];
    end
  end

  // Sub clock pins act as port I/O when not in oscillator mode
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      subclock_pin_out    <= 2'h0;
      subclock_pin_oe_out <= 2'h0;
    end else begin
      subclock_pin_out    <= subclock_pin_data_in;
      subclock_pin_oe_out <= osc_mode_r[SUBPIN_BIT] ? 2'h0 : ~pin_dir_r;
    end
  end
endmodule : cgs_clock_generator
`default_nettype wire

//--- tb/cgs_osc_model.sv
// Oscillator sources seen by the clock generator
`timescale 1ns/100ps
`default_nettype none
module cgs_osc_model (
  input  wire logic clk_in,            // System clock
  input  wire logic main_on_in,        // Main osc enabled
  input  wire logic sub_on_in,         // Sub osc enabled
  output logic      main_xtal_out = 0, // Crystal main pulse
  output logic      main_ext_out = 0,  // External main pulse
  output logic      sub_xtal_out = 0,  // Crystal sub pulse
  output logic      sub_ext_out = 0    // External sub pulse
);
  logic [3:0] ph_r = 4'h0;
  // A crystal swings only while enabled; external inputs run free
  always @(posedge clk_in) begin
    ph_r          <= ph_r + 4'h1;
    main_xtal_out <= main_on_in && (ph_r[1:0] == 2'h0);
    main_ext_out  <= (ph_r[1:0] == 2'h2);
    sub_xtal_out  <= sub_on_in && (ph_r[2:0] == 3'h3);
    sub_ext_out   <= (ph_r[2:0] == 3'h7);
  end
endmodule : cgs_osc_model
`default_nettype wire

//--- tb/cgs_clock_generator_asserts.sv
// Port checks of the clock generator
`timescale 1ns/100ps
`default_nettype none
module cgs_clock_generator_asserts (
  input wire logic                 clk_in,              // Clock
  input wire logic                 reset_in,            // Reset
  input wire logic                 avs_read_in,         // Read
  input wire logic                 avs_write_in,        // Write
  input wire logic                 avs_waitrequest_out, // Stall
  input wire cgs_pkg::cgs_option_s option_straps_in,    // Straps
  input wire logic                 cpu_clk_en_out,      // CPU pulse
  input wire logic                 watchdog_clk_en_out, // Watchdog pulse
  input wire logic                 timer_one_ls_en_out, // Timer pulse
  input wire logic                 cpu_reset_out,       // CPU reset
  input wire logic                 cpu_halted_out,      // STOP
  input wire logic                 hs_osc_on_out,       // Fast osc
  input wire logic                 ls_osc_on_out,       // Slow osc
  input wire logic                 main_osc_on_out      // Main osc
);
  import cgs_pkg::*;
  logic [15:0] rst_cnt_r;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  // CPU reset hold length
  always_ff @(posedge clk_in) begin
    if (reset_in || !cpu_reset_out) rst_cnt_r <= 16'h0000;
    else rst_cnt_r <= rst_cnt_r + 16'h0001;
  end
  a_reset_state: assert property ($fell(reset_in) |-> cpu_reset_out && avs_waitrequest_out)
    else $error("outputs not in reset state");
  a_wait_once: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("late answer");
  a_wait_short: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("wait low too long");
  a_start_fast: assert property ($fell(cpu_reset_out) |-> hs_osc_on_out && ls_osc_on_out)
    else $error("oscillators off at CPU start");
  a_slow_fixed: assert property (!option_straps_in.ls_stoppable && !cpu_reset_out |-> ls_osc_on_out)
    else $error("fixed slow osc stopped");
  a_slow_users: assert property ((watchdog_clk_en_out || timer_one_ls_en_out) |->
    ls_osc_on_out || $past(ls_osc_on_out))
    else $error("slow pulse, osc off");
  a_stop_halts: assert property ($rose(cpu_halted_out) |-> ##[0:2] (!hs_osc_on_out && !main_osc_on_out))
    else $error("clocks run in STOP");
  a_halt_quiet: assert property (cpu_halted_out [*3] |-> !cpu_clk_en_out)
    else $error("CPU pulse while halted");
  a_no_runt: assert property (cpu_clk_en_out |=> !cpu_clk_en_out)
    else $error("short CPU period");
  a_reset_len: assert property ($fell(cpu_reset_out) |-> (option_straps_in.poweron_clear_mode ?
    (rst_cnt_r >= RESET_PROC_CYC && rst_cnt_r <= RESET_PROC_CYC + 3) :
    (rst_cnt_r >= REG_STAB_CYC + RESET_PROC_CYC)))
    else $error("wrong CPU reset length");
  c_wake: cover property ($fell(cpu_halted_out));
  c_slow_stop: cover property ($fell(ls_osc_on_out));
  c_fast_stop: cover property ($fell(hs_osc_on_out));
endmodule : cgs_clock_generator_asserts
bind cgs_clock_generator cgs_clock_generator_asserts u_asserts (.*);
`default_nettype wire

//--- tb/cgs_clock_generator_tb_top.sv
// Self-checking testbench of the clock generator
`timescale 1ns/100ps
`default_nettype none
module cgs_clock_generator_tb_top;
  import cgs_pkg::*;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic        stop_rel = 1'b0;
  logic [1:0]  pin_dat = 2'h2;
  cgs_option_s straps = 3'b111;
  logic [31:0] rdat, q;
  logic        wt, cpu_en, wd_en, cpu_rst, halted, hs_on, ls_on, main_on, sub_on, mx, me, sx, se;
  logic [1:0]  pin_oe, pin_o;
  logic [7:0]  prev;
  int          err_total = 0;
  int          checked = 0;
  int          k, w;
  // Clock and hang guard
  initial forever #20 clk_in = ~clk_in;
  initial begin
    #(40 * 40000);
    err_total++;
    results();
  end
  cgs_osc_model u_osc (.clk_in(clk_in), .main_on_in(main_on), .sub_on_in(sub_on),
    .main_xtal_out(mx), .main_ext_out(me), .sub_xtal_out(sx), .sub_ext_out(se));
  cgs_clock_generator #(.STAB_SHIFT(8)) uut (
    .clk_in(clk_in), .reset_in(reset_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdat), .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
    .option_straps_in(straps), .supply_1v59_ok_in(1'b1), .supply_2v7_ok_in(1'b1),
    .stop_release_in(stop_rel), .main_crystal_osc_in(mx), .ext_main_clock_pin_in(me),
    .sub_crystal_osc_in(sx), .ext_sub_clock_pin_in(se), .subclock_pin_data_in(pin_dat),
    .cpu_clk_en_out(cpu_en), .periph_clk_en_out(), .watchdog_clk_en_out(wd_en),
    .timer_one_ls_en_out(), .cpu_reset_out(cpu_rst), .cpu_halted_out(halted),
    .hs_osc_on_out(hs_on), .ls_osc_on_out(ls_on), .main_osc_on_out(main_on),
    .sub_osc_on_out(sub_on), .subclock_pin_out(pin_o), .subclock_pin_oe_out(pin_oe));
  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One bus access
  task automatic bus(input logic w_in, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    addr <= a;
    wr <= w_in;
    rd <= !w_in;
    wdat <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (wt !== 1'b0 && n < 20);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) check("bus_answer", 32'h0, 32'h1);
  endtask : bus
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0);
    check(nm, q, exp);
  endtask : rd_chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask : idle
  // Pulse counts
  task automatic count(input int n);
    k = 0;
    w = 0;
    repeat (n) begin
      @(posedge clk_in);
      if (cpu_en === 1'b1) k++;
      if (wd_en === 1'b1) w++;
    end
  endtask : count
  task automatic do_reset(input cgs_option_s s);
    int n;
    @(posedge clk_in);
    reset_in <= 1'b1;
    straps <= s;
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    n = 0;
    while (cpu_rst !== 1'b0 && n < 4000) begin
      @(posedge clk_in);
      n++;
    end
    check("cpu_run", cpu_rst, 32'h0);
  endtask : do_reset
  task automatic results();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  initial begin
    logic [7:0] rst_tab [10];
    rst_tab = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h05, 8'h01, 8'hFF, 8'h00, 8'h00};
    do_reset(3'b111);
    check("hs_on", hs_on, 32'h1);
    check("ls_on", ls_on, 32'h1);
    for (int i = 0; i < 10; i++) rd_chk(8'(i * 4), rst_tab[i], "reset_value");
    count(1000);
    check("cpu_rate", k >= 159 && k <= 161, 32'h1);
    check("wdt_rate", w >= 9 && w <= 10, 32'h1);
    $display("start-up test done");
    prev = 8'h05;
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, ADDR_STAB_SEL, 32'(c));
      if (c >= 1 && c <= 5) prev = 8'(c);
      rd_chk(ADDR_STAB_SEL, prev, "stab_sel");
    end
    bus(1'b1, ADDR_INT_OSC, 32'h2);
    idle(4);
    check("ls_stop", ls_on, 32'h0);
    count(300);
    check("wdt_off", w, 32'h0);
    bus(1'b1, ADDR_INT_OSC, 32'h0);
    $display("select and slow test done");
    bus(1'b1, ADDR_OSC_MODE, 32'h40);
    bus(1'b1, ADDR_MAIN_OSC, 32'h0);
    idle(4);
    check("main_on", main_on, 32'h1);
    prev = 8'h00;
    for (int i = 0; i < 500; i++) begin
      bus(1'b0, ADDR_STAB_STAT, 32'h0);
      check("stab_order", q[7:0] >= prev && ((8'h20 - q[7:0]) & (8'h1F - q[7:0])) == 8'h00, 32'h1);
      prev = q[7:0];
    end
    check("stab_full", prev, 32'h1F);
    bus(1'b1, ADDR_MAIN_SEL, 32'h1);
    idle(20);
    rd_chk(ADDR_MAIN_SEL, 32'h3, "main_sel");
    bus(1'b1, ADDR_INT_OSC, 32'h1);
    idle(4);
    check("hs_stop", hs_on, 32'h0);
    count(1000);
    check("main_rate", k >= 124 && k <= 126, 32'h1);
    bus(1'b1, ADDR_CPU_CLK, 32'h2);
    bus(1'b1, ADDR_CPU_CLK, 32'h5);
    rd_chk(ADDR_CPU_CLK, 32'h2, "divider");
    idle(20);
    count(1000);
    check("div_rate", k >= 61 && k <= 64, 32'h1);
    bus(1'b1, ADDR_MAIN_OSC, 32'h80);
    idle(4);
    check("main_kept", main_on, 32'h1);
    $display("main clock test done");
    bus(1'b1, ADDR_STAB_SEL, 32'h1);
    bus(1'b1, ADDR_STANDBY, 32'h1);
    idle(4);
    check("halted", halted, 32'h1);
    check("stop_clocks", {hs_on, main_on}, 32'h0);
    stop_rel <= 1'b1;
    @(posedge clk_in);
    stop_rel <= 1'b0;
    w = 0;
    while (halted === 1'b1 && w < 2000) begin
      @(posedge clk_in);
      w++;
    end
    check("stop_wait", w >= 28 && w < 200, 32'h1);
    rd_chk(ADDR_STAB_STAT, 32'h10, "stab_capped");
    bus(1'b1, ADDR_PORT12, 32'h10);
    idle(3);
    check("pin_oe", pin_oe, 32'h1);
    check("pin_out", pin_o, 32'h2);
    $display("STOP and pin test done");
    do_reset(3'b010);
    bus(1'b1, ADDR_INT_OSC, 32'h2);
    idle(4);
    check("ls_fixed", ls_on, 32'h1);
    bus(1'b1, ADDR_OSC_MODE, 32'hC0);
    bus(1'b1, ADDR_MAIN_OSC, 32'h0);
    idle(4);
    rd_chk(ADDR_STAB_STAT, 32'h1F, "ext_no_wait");
    $display("second reset test done");
    results();
  end
endmodule : cgs_clock_generator_tb_top
`default_nettype wire
